// ---- hw/cpu_register_file_irq_status.sv ----
// Register file, interrupt status flops and request sampling with an AXI4-Lite view.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cpu_register_file_irq_status (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_srst,
  input  wire logic [3:0]              i_rd_byte_sel,
  output logic      [7:0]              o_rd_byte,
  input  wire logic [2:0]              i_rd_pair_sel,
  output logic      [15:0]             o_rd_pair,
  input  wire regfile_pkg::byte_wr_t   i_byte_wr,
  input  wire regfile_pkg::pair_wr_t   i_pair_wr,
  input  wire logic                    i_swap_af,
  input  wire logic                    i_swap_general,
  input  wire logic                    i_sp_push,
  input  wire logic                    i_sp_pop,
  input  wire logic                    i_pc_inc,
  input  wire logic                    i_refresh,
  output logic      [7:0]              o_refresh_addr,
  input  wire logic                    i_op_enable,
  input  wire logic                    i_op_disable,
  input  wire logic                    i_op_unmaskable_return,
  input  wire logic                    i_op_set_mode,
  input  wire logic [1:0]              i_mode_value,
  input  wire logic                    i_instr_last,
  input  wire logic                    i_nmi_n,
  input  wire logic                    i_int_n,
  input  wire logic                    i_vec_valid,
  input  wire logic [7:0]              i_vec_byte,
  output regfile_pkg::take_t           o_take,
  output logic      [15:0]             o_vec_ptr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic      [1:0]              s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [31:0]             s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp
);

  // storage: 16 swappable bytes, two 8-bit and four 16-bit registers (208 bits).
  logic [7:0]  bank_q [2][8];
  logic [7:0]  vec_base_q;
  logic [7:0]  refresh_q;
  logic [15:0] idx1_q;
  logic [15:0] idx2_q;
  logic [15:0] stack_q;
  logic [15:0] pc_q;
  logic        af_sel_q;
  logic        gp_sel_q;
  logic        enable_flop_one_q;
  logic        enable_flop_two_q;
  logic        response_kind_flop_a_q;
  logic        response_kind_flop_b_q;
  logic        nmi_meta_q;
  logic        nmi_sync_q;
  logic        nmi_prev_q;
  logic        int_meta_q;
  logic        int_sync_q;
  logic        nmi_pend_q;
  logic        nmi_take;
  logic        int_take;
  logic [1:0]  mode;
  logic        wr_go;
  logic        rd_go;
  logic [4:0]  wr_word;
  logic [4:0]  rd_word;
  logic        wr_bank_hit;
  logic        rd_bank_hit;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic        wr_hit;

  // Selects the physical copy: flags and accumulator follow one swap, the rest the other.
  function automatic logic bank_of(input logic [2:0] idx, input logic afs, input logic gps);
    bank_of = (idx >= regfile_pkg::IDX_FLAGS[2:0]) ? afs : gps;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign mode = {response_kind_flop_b_q, response_kind_flop_a_q};

  // Two-flop synchronisers; the first stage is never looked at, and a third nmi flop keeps the last level for the edge.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      nmi_meta_q <= 1'b1;
      nmi_sync_q <= 1'b1;
      nmi_prev_q <= 1'b1;
      int_meta_q <= 1'b1;
      int_sync_q <= 1'b1;
    end else begin
      nmi_meta_q <= i_nmi_n;
      nmi_sync_q <= nmi_meta_q;
      nmi_prev_q <= nmi_sync_q;
      int_meta_q <= i_int_n;
      int_sync_q <= int_meta_q;
    end
  end

  // unblockable edge latch: a new edge wins over the clearing take.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_pend_q <= (nmi_prev_q & ~nmi_sync_q) | (nmi_pend_q & ~nmi_take);
    end
  end

  // sample at last clock. unmaskable first, maskable left pending.
  assign nmi_take = i_instr_last & nmi_pend_q;
  // enable gating. any low level on the shared line pends.
  assign int_take = i_instr_last & ~nmi_pend_q & ~int_sync_q & enable_flop_one_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_op_disable) begin
      enable_flop_one_q <= 1'b0;
      enable_flop_two_q <= 1'b0;
    end else if (nmi_take) begin
      enable_flop_one_q <= 1'b0;
      enable_flop_two_q <= enable_flop_one_q;
    end else if (int_take) begin
      enable_flop_one_q <= 1'b0;
      enable_flop_two_q <= 1'b0;
    end else if (i_op_enable) begin
      enable_flop_one_q <= 1'b1;
      enable_flop_two_q <= 1'b1;
    end else if (i_op_unmaskable_return) begin
      enable_flop_one_q <= enable_flop_two_q;
    end
  end

  // reset to mode 0. modes 0 to 2; an undefined value is ignored.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      response_kind_flop_a_q <= 1'b0;
      response_kind_flop_b_q <= 1'b0;
    end else if (i_op_set_mode && i_mode_value <= regfile_pkg::MODE2) begin
      response_kind_flop_a_q <= i_mode_value[0];
      response_kind_flop_b_q <= i_mode_value[1];
    end
  end

  // fixed unmaskable target. restart 0066H. mode 1 restart 0038H.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_take <= '0;
    end else begin
      o_take.nmi  <= nmi_take;
      o_take.irq  <= int_take;
      o_take.mode <= nmi_take ? regfile_pkg::MODE1 : mode;
      o_take.addr <= nmi_take ? regfile_pkg::NMI_RESTART :
                     (mode == regfile_pkg::MODE1) ? regfile_pkg::INT1_RESTART : '0;
    end
  end

  // vectored dispatch. base high byte, even vector low. base use.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_vec_ptr <= '0;
    end else if (i_vec_valid) begin
      o_vec_ptr <= {vec_base_q, i_vec_byte & regfile_pkg::VEC_EVEN};
    end
  end

  // exchange flips which copy is presented.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      af_sel_q <= 1'b0;
      gp_sel_q <= 1'b0;
    end else begin
      af_sel_q <= af_sel_q ^ i_swap_af;
      gp_sel_q <= gp_sel_q ^ i_swap_general;
    end
  end

  // Bus handshake: write address and data are taken together once both are valid.
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign wr_word       = s_axi_awaddr[6:2];
  assign rd_word       = s_axi_araddr[6:2];
  assign wr_bank_hit   = (s_axi_awaddr[31:7] == '0) && (wr_word < regfile_pkg::W_VEC_BASE);
  assign rd_bank_hit   = (s_axi_araddr[31:7] == '0) && (rd_word < regfile_pkg::W_VEC_BASE);
  assign wr_hit = (s_axi_awaddr[31:7] == '0) && (wr_word < regfile_pkg::W_STATUS);

  // two copies. six general bytes per set. Bus writes land after datapath writes.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int b = 0; b < 2; b++) begin
        for (int r = 0; r < 8; r++) begin
          bank_q[b][r] <= '0;
        end
      end
    end else begin
      if (i_byte_wr.en && !i_byte_wr.sel[3]) begin
        bank_q[bank_of(i_byte_wr.sel[2:0], af_sel_q, gp_sel_q)][i_byte_wr.sel[2:0]]
          <= i_byte_wr.data;
      end
      // pair writes: first-named register takes the upper byte.
      if (i_pair_wr.en && i_pair_wr.sel <= regfile_pkg::PAIR_THIRD) begin
        bank_q[gp_sel_q][{i_pair_wr.sel[1:0], 1'b0}] <= i_pair_wr.data[15:8];
        bank_q[gp_sel_q][{i_pair_wr.sel[1:0], 1'b1}] <= i_pair_wr.data[7:0];
      end
      if (i_pair_wr.en && i_pair_wr.sel == regfile_pkg::PAIR_AF) begin
        bank_q[af_sel_q][regfile_pkg::IDX_ACCUM[2:0]] <= i_pair_wr.data[15:8];
        bank_q[af_sel_q][regfile_pkg::IDX_FLAGS[2:0]] <= i_pair_wr.data[7:0];
      end
      if (wr_go && wr_bank_hit && s_axi_wstrb[0]) begin
        bank_q[wr_word[3]][wr_word[2:0]] <= s_axi_wdata[7:0];
      end
    end
  end

  // vector base and refresh counter: only the low seven bits count.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      vec_base_q     <= '0;
      refresh_q      <= '0;
      o_refresh_addr <= '0;
    end else begin
      if (i_refresh) begin
        o_refresh_addr <= refresh_q;
        refresh_q      <= {refresh_q[7], refresh_q[6:0] + regfile_pkg::REFRESH_STEP};
      end
      if (i_byte_wr.en && i_byte_wr.sel == regfile_pkg::IDX_VEC_BASE) begin
        vec_base_q <= i_byte_wr.data;
      end
      if (i_byte_wr.en && i_byte_wr.sel == regfile_pkg::IDX_REFRESH) begin
        refresh_q <= i_byte_wr.data;
      end
      if (wr_go && wr_hit && s_axi_wstrb[0] && wr_word == regfile_pkg::W_VEC_BASE) begin
        vec_base_q <= s_axi_wdata[7:0];
      end
      if (wr_go && wr_hit && s_axi_wstrb[0] && wr_word == regfile_pkg::W_REFRESH) begin
        refresh_q <= s_axi_wdata[7:0];
      end
    end
  end

  // index bases, stack pointer, program counter.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      idx1_q  <= '0;
      idx2_q  <= '0;
      stack_q <= '0;
      pc_q    <= '0;
    end else begin
      if (i_sp_push) begin
        stack_q <= stack_q - regfile_pkg::STACK_STEP;
      end else if (i_sp_pop) begin
        stack_q <= stack_q + regfile_pkg::STACK_STEP;
      end
      if (i_pc_inc) begin
        pc_q <= pc_q + regfile_pkg::PC_STEP;
      end
      if (i_pair_wr.en) begin
        case (i_pair_wr.sel)
          regfile_pkg::PAIR_STACK: stack_q <= i_pair_wr.data;
          regfile_pkg::PAIR_IDX1:  idx1_q  <= i_pair_wr.data;
          regfile_pkg::PAIR_IDX2:  idx2_q  <= i_pair_wr.data;
          regfile_pkg::PAIR_PC:    pc_q    <= i_pair_wr.data;
          default: ;
        endcase
      end
      if (wr_go && wr_hit) begin
        case (wr_word)
          regfile_pkg::W_IDX1:  idx1_q  <= merge16(idx1_q, s_axi_wdata, s_axi_wstrb);
          regfile_pkg::W_IDX2:  idx2_q  <= merge16(idx2_q, s_axi_wdata, s_axi_wstrb);
          regfile_pkg::W_STACK: stack_q <= merge16(stack_q, s_axi_wdata, s_axi_wstrb);
          regfile_pkg::W_PC:    pc_q    <= merge16(pc_q, s_axi_wdata, s_axi_wstrb);
          default: ;
        endcase
      end
    end
  end

  // Datapath reads are registered, so data appears one cycle after the select.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rd_byte <= '0;
      o_rd_pair <= '0;
    end else begin
      case (i_rd_byte_sel)
        regfile_pkg::IDX_VEC_BASE: o_rd_byte <= vec_base_q;
        regfile_pkg::IDX_REFRESH:  o_rd_byte <= refresh_q;
        default: o_rd_byte <= i_rd_byte_sel[3] ? 8'h00 :
          bank_q[bank_of(i_rd_byte_sel[2:0], af_sel_q, gp_sel_q)][i_rd_byte_sel[2:0]];
      endcase
      case (i_rd_pair_sel)
        regfile_pkg::PAIR_STACK: o_rd_pair <= stack_q;
        regfile_pkg::PAIR_IDX1:  o_rd_pair <= idx1_q;
        regfile_pkg::PAIR_IDX2:  o_rd_pair <= idx2_q;
        regfile_pkg::PAIR_PC:    o_rd_pair <= pc_q;
        regfile_pkg::PAIR_AF:    o_rd_pair <= {bank_q[af_sel_q][regfile_pkg::IDX_ACCUM[2:0]],
                                               bank_q[af_sel_q][regfile_pkg::IDX_FLAGS[2:0]]};
        default: o_rd_pair <= {bank_q[gp_sel_q][{i_rd_pair_sel[1:0], 1'b0}],
                               bank_q[gp_sel_q][{i_rd_pair_sel[1:0], 1'b1}]};
      endcase
    end
  end

  // Bus read mux; the status word is read only and bus writes to it are ignored.
  always_comb begin
    rd_value = '0;
    rd_hit   = (s_axi_araddr[31:7] == '0) && (rd_word <= regfile_pkg::W_STATUS);
    if (rd_bank_hit) begin
      rd_value[7:0] = bank_q[rd_word[3]][rd_word[2:0]];
    end else begin
      case (rd_word)
        regfile_pkg::W_VEC_BASE: rd_value[7:0]  = vec_base_q;
        regfile_pkg::W_REFRESH:  rd_value[7:0]  = refresh_q;
        regfile_pkg::W_IDX1:     rd_value[15:0] = idx1_q;
        regfile_pkg::W_IDX2:     rd_value[15:0] = idx2_q;
        regfile_pkg::W_STACK:    rd_value[15:0] = stack_q;
        regfile_pkg::W_PC:       rd_value[15:0] = pc_q;
        regfile_pkg::W_STATUS: begin
          rd_value[regfile_pkg::ST_EN1] = enable_flop_one_q;
          rd_value[regfile_pkg::ST_EN2] = enable_flop_two_q;
          rd_value[regfile_pkg::ST_KA]  = response_kind_flop_a_q;
          rd_value[regfile_pkg::ST_KB]  = response_kind_flop_b_q;
          rd_value[regfile_pkg::ST_AFS] = af_sel_q;
          rd_value[regfile_pkg::ST_GPS] = gp_sel_q;
          rd_value[regfile_pkg::ST_NMP] = nmi_pend_q;
        end
        default: rd_value = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= regfile_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit || wr_word == regfile_pkg::W_STATUS) && s_axi_awaddr[31:7] == '0
                      ? regfile_pkg::RESP_OKAY : regfile_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= regfile_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_hit ? regfile_pkg::RESP_OKAY : regfile_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Unmaskable take restarts at its fixed address, whatever mode is set.
  a_nmi_target: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    nmi_take |=> o_take.nmi && o_take.addr == 16'h0066 && !o_take.irq)
    else $error("unmaskable take did not restart at the fixed address");

  a_nmi_beats_int: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_instr_last && nmi_pend_q && !int_sync_q) |-> !int_take)
    else $error("maskable request taken while unmaskable one pending");

  a_int_masked: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_take.irq |-> $past(enable_flop_one_q))
    else $error("maskable request taken while disabled");

  a_sample_point: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (o_take.nmi || o_take.irq) |-> $past(i_instr_last))
    else $error("request taken outside the last clock");

  a_nmi_copy: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (nmi_take && !i_op_disable) |=> !enable_flop_one_q &&
      enable_flop_two_q == $past(enable_flop_one_q))
    else $error("enable flops wrong after unmaskable accept");

  a_mode1_target: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (o_take.irq && o_take.mode == 2'h1) |-> o_take.addr == 16'h0038)
    else $error("mode 1 take not at its restart address");

  a_vec_pointer: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_vec_valid |=> o_vec_ptr == {$past(vec_base_q), $past(i_vec_byte) & 8'hFE})
    else $error("vector pointer malformed");

  a_refresh_seven: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_refresh && !i_byte_wr.en && !wr_go) |=> refresh_q[7] == $past(refresh_q[7]) &&
      refresh_q[6:0] == $past(refresh_q[6:0]) + 7'h01 && o_refresh_addr == $past(refresh_q))
    else $error("refresh counter step wrong");

  a_swap_flip: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_swap_general |=> gp_sel_q != $past(gp_sel_q))
    else $error("exchange did not switch the general copy");

  a_mode_reset: assert property (@(posedge i_clk_sys)
    i_srst |=> mode == 2'h0 && !enable_flop_one_q && !enable_flop_two_q)
    else $error("reset did not select mode 0 with enables clear");

endmodule

// ---- hw/regfile_pkg.sv ----
// Constants, types and register map for the processor register file.
package regfile_pkg;

  // Byte register index for the datapath port; the bus map keeps its order for bank bytes 0 to 7 only.
  localparam logic [3:0] IDX_FIRST_HIGH  = 4'h0;
  localparam logic [3:0] IDX_FIRST_LOW   = 4'h1;
  localparam logic [3:0] IDX_SECOND_HIGH = 4'h2;
  localparam logic [3:0] IDX_SECOND_LOW  = 4'h3;
  localparam logic [3:0] IDX_THIRD_HIGH  = 4'h4;
  localparam logic [3:0] IDX_THIRD_LOW   = 4'h5;
  localparam logic [3:0] IDX_FLAGS       = 4'h6;
  localparam logic [3:0] IDX_ACCUM       = 4'h7;
  localparam logic [3:0] IDX_VEC_BASE    = 4'h8;
  localparam logic [3:0] IDX_REFRESH     = 4'h9;

  // Pair index for the 16-bit port.
  localparam logic [2:0] PAIR_FIRST  = 3'h0;
  localparam logic [2:0] PAIR_SECOND = 3'h1;
  localparam logic [2:0] PAIR_THIRD  = 3'h2;
  localparam logic [2:0] PAIR_STACK  = 3'h3;
  localparam logic [2:0] PAIR_IDX1   = 3'h4;
  localparam logic [2:0] PAIR_IDX2   = 3'h5;
  localparam logic [2:0] PAIR_PC     = 3'h6;
  localparam logic [2:0] PAIR_AF     = 3'h7;

  // Bus word index (byte address divided by four).
  localparam logic [4:0] W_MAIN_BASE = 5'h00;
  localparam logic [4:0] W_ALT_BASE  = 5'h08;
  localparam logic [4:0] W_VEC_BASE  = 5'h10;
  localparam logic [4:0] W_REFRESH   = 5'h11;
  localparam logic [4:0] W_IDX1      = 5'h12;
  localparam logic [4:0] W_IDX2      = 5'h13;
  localparam logic [4:0] W_STACK     = 5'h14;
  localparam logic [4:0] W_PC        = 5'h15;
  localparam logic [4:0] W_STATUS    = 5'h16;

  // Status word bit positions.
  localparam int ST_EN1 = 0;
  localparam int ST_EN2 = 1;
  localparam int ST_KA  = 2;
  localparam int ST_KB  = 3;
  localparam int ST_AFS = 4;
  localparam int ST_GPS = 5;
  localparam int ST_NMP = 6;

  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;

  localparam logic [15:0] NMI_RESTART  = 16'h0066;
  localparam logic [15:0] INT1_RESTART = 16'h0038;
  localparam logic [15:0] STACK_STEP   = 16'h0002;
  localparam logic [15:0] PC_STEP      = 16'h0001;
  localparam logic [6:0]  REFRESH_STEP = 7'h01;
  localparam logic [7:0]  VEC_EVEN     = 8'hFE;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic       en;
    logic [3:0] sel;
    logic [7:0] data;
  } byte_wr_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  sel;
    logic [15:0] data;
  } pair_wr_t;

  typedef struct packed {
    logic        nmi;
    logic        irq;
    logic [1:0]  mode;
    logic [15:0] addr;
  } take_t;

endpackage

// ---- testbench/periph_model.sv ----
// Peripheral side model: wired-OR maskable requesters, unmaskable source, vector supplier.
`timescale 1ns/1ps
module periph_model (
  input  wire logic       i_clk_sys,
  input  wire logic [1:0] i_int_req,
  input  wire logic       i_nmi_req,
  input  wire logic       i_vec_req,
  input  wire logic [7:0] i_vec_raw,
  output logic            o_int_n,
  output logic            o_nmi_n,
  output logic            o_vec_valid,
  output logic [7:0]      o_vec_byte
);
  assign o_int_n = ~|i_int_req;
  assign o_nmi_n = ~i_nmi_req;
  always_ff @(posedge i_clk_sys) begin
    o_vec_valid <= i_vec_req;
    // Outside a vector cycle the bus shows junk, never the last value.
    o_vec_byte  <= i_vec_req ? (i_vec_raw & 8'hFE) : ~i_vec_raw;
  end
endmodule

// ---- testbench/cpu_register_file_irq_status_tb.sv ----
// Self-checking bench for the register file and interrupt sampling front end.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpu_register_file_irq_status_tb;
  logic                  i_clk_sys, i_srst, i_swap_af, i_swap_general, i_sp_push, i_sp_pop;
  logic                  i_pc_inc, i_refresh, i_op_enable, i_op_disable, i_op_unmaskable_return;
  logic                  i_op_set_mode, i_instr_last, i_nmi_n, i_int_n, i_vec_valid, nmi_req;
  logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                  vec_req;
  logic [1:0]            i_mode_value, s_axi_bresp, s_axi_rresp, int_req, r;
  logic [2:0]            i_rd_pair_sel;
  logic [3:0]            i_rd_byte_sel, s_axi_wstrb;
  logic [7:0]            o_rd_byte, o_refresh_addr, i_vec_byte, vec_raw;
  logic [15:0]           o_rd_pair, o_vec_ptr, lf;
  logic [31:0]           s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [31:0]           ex [22];
  regfile_pkg::byte_wr_t i_byte_wr;
  regfile_pkg::pair_wr_t i_pair_wr;
  regfile_pkg::take_t    o_take, t;
  int                    fail_count, compares;

  cpu_register_file_irq_status u_dut (.*);
  periph_model u_periph (.i_clk_sys(i_clk_sys), .i_int_req(int_req), .i_nmi_req(nmi_req),
    .i_vec_req(vec_req), .i_vec_raw(vec_raw), .o_int_n(i_int_n), .o_nmi_n(i_nmi_n),
    .o_vec_valid(i_vec_valid), .o_vec_byte(i_vec_byte));

  initial begin
    i_clk_sys = 1'h0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // Holds each channel until its own handshake edge, as the bus demands.
  task automatic axi(input logic w, input logic [31:0] a, d);
    @(posedge i_clk_sys);
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    s_axi_araddr  <= a;
    do @(posedge i_clk_sys); while (w ? !s_axi_awready : !s_axi_arready);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid  <= 1'h0;
    s_axi_arvalid <= 1'h0;
    do @(posedge i_clk_sys); while (w ? !s_axi_bvalid : !s_axi_rvalid);
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdc(input logic [31:0] a, e);
    axi(1'h0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic sample;
    @(posedge i_clk_sys);
    i_instr_last <= 1'h1;
    @(posedge i_clk_sys);
    i_instr_last <= 1'h0;
    #1;
    t = o_take;
  endtask
  task automatic pulse_ops(input logic en, dis, ret, input logic [1:0] m);
    @(posedge i_clk_sys);
    {i_op_enable, i_op_disable, i_op_unmaskable_return, i_op_set_mode} <= {en, dis, ret, en};
    i_mode_value <= m;
    @(posedge i_clk_sys);
    {i_op_enable, i_op_disable, i_op_unmaskable_return, i_op_set_mode} <= 4'h0;
  endtask
  task automatic give_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {i_swap_af, i_swap_general, i_sp_push, i_sp_pop, i_pc_inc, i_refresh, i_op_enable,
     i_op_disable, i_op_unmaskable_return, i_op_set_mode, i_instr_last, i_mode_value, int_req,
     s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, i_rd_pair_sel,
     i_rd_byte_sel, nmi_req, vec_req, vec_raw, i_byte_wr, i_pair_wr, s_axi_awaddr,
     s_axi_wdata, s_axi_araddr} = '0;
    i_srst = 1'h1;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    compares = 0;
    lf = 16'h0018;
    tick(6);
    i_srst <= 1'h0;
    rdc(32'h58, 32'h0);
    for (int w = 0; w < 22; w++) begin
      lf = lfsr(lf);
      ex[w] = w < 18 ? {24'h0, lf[7:0]} : {16'h0, lf};
      axi(1'h1, 32'(w * 4), {16'h0, lf});
    end
    for (int w = 0; w < 22; w++) rdc(32'(w * 4), ex[w]);
    axi(1'h1, 32'h5C, 32'h0);
    `CHK(r, regfile_pkg::RESP_SLVERR)
    axi(1'h0, 32'h5C, 32'h0);
    `CHK(r, regfile_pkg::RESP_SLVERR)
    $display("storage test done");
    axi(1'h1, 32'h0, 32'h12);
    axi(1'h1, 32'h4, 32'h34);
    axi(1'h1, 32'h20, 32'h56);
    axi(1'h1, 32'h3C, 32'hB2);
    tick(2);
    {i_swap_af, i_swap_general} <= 2'h3;
    i_rd_pair_sel <= regfile_pkg::PAIR_AF;
    #1;
    `CHK(o_rd_pair, 16'h1234)
    tick(1);
    {i_swap_af, i_swap_general} <= 2'h0;
    tick(3);
    #1;
    `CHK(o_rd_byte, 8'h56)
    `CHK(o_rd_pair[15:8], 8'hB2)
    lf = lfsr(lf);
    axi(1'h1, 32'h50, {16'h0, lf});
    axi(1'h1, 32'h54, {16'h0, lf});
    {i_sp_push, i_pc_inc} <= 2'h3;
    i_pair_wr <= {1'h1, regfile_pkg::PAIR_SECOND, lf};
    tick(1);
    {i_sp_push, i_pc_inc} <= 2'h0;
    i_pair_wr.en <= 1'h0;
    rdc(32'h50, {16'h0, lf - 16'h0002});
    rdc(32'h54, {16'h0, lf + 16'h0001});
    rdc(32'h28, {24'h0, lf[15:8]});
    rdc(32'h2C, {24'h0, lf[7:0]});
    axi(1'h1, 32'h44, 32'hFF);
    i_refresh <= 1'h1;
    tick(1);
    i_refresh <= 1'h0;
    rdc(32'h44, 32'h80);
    `CHK(o_refresh_addr, 8'hFF)
    axi(1'h1, 32'h40, {24'h0, lf[15:8]});
    vec_req <= 1'h1;
    vec_raw <= lf[7:0] | 8'h01;
    tick(1);
    vec_req <= 1'h0;
    tick(3);
    `CHK(o_vec_ptr, {lf[15:8], lf[7:0] & 8'hFE})
    $display("register test done");
    for (int m = 0; m < 3; m++) begin
      int_req <= 2'(m + 1);
      pulse_ops(1'h1, 1'h0, 1'h0, 2'(m));
      tick(4);
      `CHK(o_take.irq, 1'h0)
      sample;
      `CHK(t, {2'h1, 2'(m), m == 1 ? regfile_pkg::INT1_RESTART : 16'h0000})
      sample;
      `CHK(t.irq, 1'h0)
    end
    pulse_ops(1'h1, 1'h0, 1'h0, regfile_pkg::MODE2);
    nmi_req <= 1'h1;
    tick(4);
    sample;
    `CHK(t, {2'h2, 2'h1, regfile_pkg::NMI_RESTART})
    rdc(32'h58, 32'h3A);
    pulse_ops(1'h0, 1'h0, 1'h1, 2'h0);
    sample;
    `CHK(t.irq, 1'h1)
    pulse_ops(1'h1, 1'h1, 1'h0, 2'h1);
    sample;
    `CHK(t.irq, 1'h0)
    $display("interrupt test done");
    give_verdict;
  end

  initial begin
    tick(6000);
    fail_count++;
    give_verdict;
  end
endmodule
